/* hdl/cnmt_decode.sv */
// Command frame decoder: filters the identifier and the node address.
module cnmt_decode (
  input wire logic clk,
  input wire logic reset,
  input wire logic frame_valid,
  input wire cnmt_pkg::cnmt_frame_t frame,
  input wire logic [6:0] node_id,
  output logic cmd_valid,
  output logic [7:0] cmd_code
);

  logic valid_q;
  logic valid_d;
  logic [7:0] code_q;
  logic [7:0] code_d;
  logic [7:0] node_byte;
  logic known;

  // Only frames of at least two bytes on the command identifier addressed to us or to all are passed on.
  always_comb begin
    node_byte = frame.data[cnmt_pkg::NODE_BYTE_LSB +: 8];
    code_d = frame.data[cnmt_pkg::CMD_BYTE_LSB +: 8];
    known = (code_d == cnmt_pkg::CMD_START) || (code_d == cnmt_pkg::CMD_STOP) ||
            (code_d == cnmt_pkg::CMD_PREOP) || (code_d == cnmt_pkg::CMD_RESET_NODE) ||
            (code_d == cnmt_pkg::CMD_RESET_COMM);
    valid_d = frame_valid && (frame.id == cnmt_pkg::CMD_FRAME_ID)
              && (frame.dlc >= 4'h2)
              && ((node_byte == {1'b0, cnmt_pkg::BROADCAST_ID})
                  || (node_byte == {1'b0, node_id}))
              && known;
  end

  // Register the decoded command so the state machine sees a clean pulse.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      valid_q <= 1'b0;
      code_q <= 8'h00;
    end else begin
      valid_q <= valid_d;
      code_q <= code_d;
    end
  end

  assign cmd_valid = valid_q;
  assign cmd_code = code_q;

endmodule : cnmt_decode

/* hdl/cnmt_pkg.sv */
// Package with constants, states and carrier types for the network-management slave.
package cnmt_pkg;

  // Command codes carried in the first data byte of a command frame.
  localparam logic [7:0] CMD_START = 8'h01;
  localparam logic [7:0] CMD_STOP = 8'h02;
  localparam logic [7:0] CMD_PREOP = 8'h80;
  localparam logic [7:0] CMD_RESET_NODE = 8'h81;
  localparam logic [7:0] CMD_RESET_COMM = 8'h82;

  // Frame identifier reserved for command frames, and the broadcast node identifier.
  localparam logic [10:0] CMD_FRAME_ID = 11'h000;
  localparam logic [6:0] BROADCAST_ID = 7'h00;

  // Reactions to a communication error.
  localparam logic [7:0] REACT_PREOP = 8'h00;
  localparam logic [7:0] REACT_KEEP = 8'h01;
  localparam logic [7:0] REACT_STOP = 8'h02;
  localparam logic [7:0] REACT_RESET = 8'h00;

  // State codes reported in guarding replies and heartbeats.
  localparam logic [6:0] CODE_BOOT = 7'h00;
  localparam logic [6:0] CODE_STOPPED = 7'h04;
  localparam logic [6:0] CODE_OPER = 7'h05;
  localparam logic [6:0] CODE_PREOP = 7'h7f;

  // Field positions inside a received frame payload.
  localparam int CMD_BYTE_LSB = 0;
  localparam int NODE_BYTE_LSB = 8;

  // Initialisation time and its count of 25 ns cycles.
  localparam int CLK_HZ = 40_000_000;
  localparam int INIT_TIME_NS = 1000;
  localparam int INIT_CYCLES = (INIT_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // Node states.
  typedef enum logic [2:0] {
    CNMT_INIT_NODE = 3'b000,
    CNMT_INIT_COMM = 3'b001,
    CNMT_PREOP = 3'b010,
    CNMT_OPER = 3'b011,
    CNMT_STOPPED = 3'b100
  } cnmt_state_t;

  // A received frame as handed over by the CAN controller.
  typedef struct packed {
    logic [10:0] id;
    logic [3:0] dlc;
    logic [15:0] data;
  } cnmt_frame_t;

  // Communication errors that trigger the configured reaction.
  typedef struct packed {
    logic bus_off;
    logic life_guard;
    logic hb_timeout;
  } cnmt_err_t;

  // Services that the current state lets through.
  typedef struct packed {
    logic sdo;
    logic emcy;
    logic sync;
    logic guard;
    logic pdo;
  } cnmt_allow_t;

endpackage : cnmt_pkg

/* hdl/cnmt_slave.sv */
// Network-management slave state machine with service gating and error reaction.
module cnmt_slave #(
  parameter int TPDO_COUNT = 4,
  parameter int INIT_CYCLES = cnmt_pkg::INIT_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [6:0] node_id,
  input wire logic frame_valid,
  input wire cnmt_pkg::cnmt_frame_t frame,
  input wire logic [7:0] comm_err_reaction,
  input wire logic [TPDO_COUNT-1:0] tpdo_enable,
  input wire cnmt_pkg::cnmt_err_t comm_err,
  input wire logic guard_reply_sent,
  output cnmt_pkg::cnmt_state_t state,
  output cnmt_pkg::cnmt_allow_t allow,
  output logic bootup_send,
  output logic [TPDO_COUNT-1:0] tpdo_send,
  output logic reload_app_params,
  output logic reload_comm_params,
  output logic [7:0] guard_state_byte,
  output logic [7:0] heartbeat_state_byte
);

  // Elaboration check: a zero-length init count or burst vector would leave the counter or outputs meaningless.
  if (TPDO_COUNT < 1 || TPDO_COUNT > 512 || INIT_CYCLES < 1) begin : g_param_check
    $error("cnmt_slave: unsupported parameter values");
  end

  localparam int CW = $clog2(INIT_CYCLES + 1);

  cnmt_pkg::cnmt_state_t state_q;
  cnmt_pkg::cnmt_state_t state_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic boot_q;
  logic boot_d;
  logic [TPDO_COUNT-1:0] tpdo_q;
  logic [TPDO_COUNT-1:0] tpdo_d;
  logic app_q;
  logic app_d;
  logic comm_q;
  logic comm_d;
  logic toggle_q;
  logic toggle_d;
  logic [7:0] gbyte_q;
  logic [7:0] gbyte_d;
  logic [7:0] hbyte_q;
  logic [7:0] hbyte_d;
  logic [7:0] react_q;
  logic [7:0] react_d;
  logic cmd_valid;
  logic [7:0] cmd_code;
  logic err_any;

  // Maps a state to the code reported on the network.
  function automatic logic [6:0] state_code(input cnmt_pkg::cnmt_state_t s);
    logic [6:0] c;
    c = cnmt_pkg::CODE_BOOT;
    unique case (s)
      cnmt_pkg::CNMT_PREOP: c = cnmt_pkg::CODE_PREOP;
      cnmt_pkg::CNMT_OPER: c = cnmt_pkg::CODE_OPER;
      cnmt_pkg::CNMT_STOPPED: c = cnmt_pkg::CODE_STOPPED;
      default: c = cnmt_pkg::CODE_BOOT;
    endcase
    return c;
  endfunction : state_code

  cnmt_decode u_decode (
    .clk(clk),
    .reset(reset),
    .frame_valid(frame_valid),
    .frame(frame),
    .node_id(node_id),
    .cmd_valid(cmd_valid),
    .cmd_code(cmd_code)
  );

  assign err_any = comm_err.bus_off | comm_err.life_guard | comm_err.hb_timeout;

  // Next state: commands win over an error reaction in the same cycle, since they are explicit.
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    boot_d = 1'b0;
    tpdo_d = '0;
    app_d = 1'b0;
    comm_d = 1'b0;
    react_d = react_q;
    unique case (state_q)
      cnmt_pkg::CNMT_INIT_NODE, cnmt_pkg::CNMT_INIT_COMM: begin
        if (cnt_q == CW'(INIT_CYCLES - 1)) begin
          state_d = cnmt_pkg::CNMT_PREOP;
          boot_d = 1'b1;
          cnt_d = '0;
        end else begin
          cnt_d = cnt_q + CW'(1);
        end
      end
      default: begin
        if (cmd_valid) begin
          unique case (cmd_code)
            cnmt_pkg::CMD_START: begin
              if (state_q != cnmt_pkg::CNMT_OPER) begin
                state_d = cnmt_pkg::CNMT_OPER;
              end
            end
            cnmt_pkg::CMD_STOP: state_d = cnmt_pkg::CNMT_STOPPED;
            cnmt_pkg::CMD_PREOP: state_d = cnmt_pkg::CNMT_PREOP;
            cnmt_pkg::CMD_RESET_NODE: begin
              state_d = cnmt_pkg::CNMT_INIT_NODE;
              app_d = 1'b1;
              comm_d = 1'b1;
              cnt_d = '0;
            end
            cnmt_pkg::CMD_RESET_COMM: begin
              state_d = cnmt_pkg::CNMT_INIT_COMM;
              comm_d = 1'b1;
              cnt_d = '0;
            end
            default: state_d = state_q;
          endcase
        end else if (err_any) begin
          if (react_q == cnmt_pkg::REACT_PREOP) begin
            state_d = cnmt_pkg::CNMT_PREOP;
          end else if (react_q == cnmt_pkg::REACT_STOP) begin
            state_d = cnmt_pkg::CNMT_STOPPED;
          end
        end
        if (state_d == cnmt_pkg::CNMT_OPER && state_q != cnmt_pkg::CNMT_OPER) begin
          tpdo_d = tpdo_enable;
        end
      end
    endcase
    // The reaction code is sampled during initialisation so it tracks the configured value.
    if (state_q == cnmt_pkg::CNMT_INIT_NODE || state_q == cnmt_pkg::CNMT_INIT_COMM) begin
      react_d = comm_err_reaction;
    end
  end

  // State registers; reset lands in node initialisation with the default reaction.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= cnmt_pkg::CNMT_INIT_NODE;
      cnt_q <= '0;
      boot_q <= 1'b0;
      tpdo_q <= '0;
      app_q <= 1'b1;
      comm_q <= 1'b1;
      react_q <= cnmt_pkg::REACT_RESET;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      boot_q <= boot_d;
      tpdo_q <= tpdo_d;
      app_q <= app_d;
      comm_q <= comm_d;
      react_q <= react_d;
    end
  end

  // Guard reply byte toggles bit 7 after each reply; reinitialisation restarts it at zero.
  always_comb begin
    toggle_d = toggle_q;
    if (state_q == cnmt_pkg::CNMT_INIT_NODE || state_q == cnmt_pkg::CNMT_INIT_COMM) begin
      toggle_d = 1'b0;
    end else if (guard_reply_sent) begin
      toggle_d = ~toggle_q;
    end
    gbyte_d = {toggle_d, state_code(state_d)};
    hbyte_d = {1'b0, state_code(state_d)};
  end

  // Status byte registers.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      toggle_q <= 1'b0;
      gbyte_q <= 8'h00;
      hbyte_q <= 8'h00;
    end else begin
      toggle_q <= toggle_d;
      gbyte_q <= gbyte_d;
      hbyte_q <= hbyte_d;
    end
  end

  // Service gating per state; heartbeat and guarding survive stopped.
  always_comb begin
    allow = '0;
    unique case (state_q)
      cnmt_pkg::CNMT_PREOP: begin
        allow.sdo = 1'b1;
        allow.emcy = 1'b1;
        allow.sync = 1'b1;
        allow.guard = 1'b1;
        allow.pdo = 1'b0;
      end
      cnmt_pkg::CNMT_OPER: allow = '1;
      cnmt_pkg::CNMT_STOPPED: allow.guard = 1'b1;
      default: allow = '0;
    endcase
  end

  assign state = state_q;
  assign bootup_send = boot_q;
  assign tpdo_send = tpdo_q;
  assign reload_app_params = app_q;
  assign reload_comm_params = comm_q;
  assign guard_state_byte = gbyte_q;
  assign heartbeat_state_byte = hbyte_q;

endmodule : cnmt_slave

/* verification/cnmt_master.sv */
// Model of the network-management master that sends command frames.
module cnmt_master (
  input wire logic clk,
  output logic frame_valid,
  output cnmt_pkg::cnmt_frame_t frame
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    frame_valid = 1'b0;
    frame = '0;
  end
  // One frame stands one cycle; afterwards the fields flip so stale bytes never pass for a frame.
  task automatic send(input logic [10:0] id, input logic [7:0] code, input logic [6:0] node);
    @(posedge clk);
    #1;
    frame_valid = 1'b1;
    frame = {id, 4'h2, 1'b0, node, code};
    @(posedge clk);
    #1;
    frame_valid = 1'b0;
    frame = ~frame;
  endtask : send
endmodule : cnmt_master

/* verification/cnmt_slave_props.sv */
// Checker for the port relations of the network-management slave.
module cnmt_slave_props #(
  parameter int TPDO_COUNT = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [6:0] node_id,
  input wire logic frame_valid,
  input wire cnmt_pkg::cnmt_frame_t frame,
  input wire logic [7:0] comm_err_reaction,
  input wire logic [TPDO_COUNT-1:0] tpdo_enable,
  input wire cnmt_pkg::cnmt_err_t comm_err,
  input wire logic guard_reply_sent,
  input wire cnmt_pkg::cnmt_state_t state,
  input wire cnmt_pkg::cnmt_allow_t allow,
  input wire logic bootup_send,
  input wire logic [TPDO_COUNT-1:0] tpdo_send,
  input wire logic reload_app_params,
  input wire logic reload_comm_params,
  input wire logic [7:0] guard_state_byte
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Running means past initialisation; the code is what a guard reply reports.
  logic run;
  logic start_me;
  logic [6:0] code;
  assign run = state[2] | state[1];
  assign start_me = frame_valid && frame.id == 11'h000 && frame.dlc >= 4'h2 && frame.data == {1'b0, node_id, 8'h01};
  assign code = state == cnmt_pkg::CNMT_STOPPED ? 7'h04 : state == cnmt_pkg::CNMT_OPER ? 7'h05 : 7'h7f;
  preop_gate_a: assert property (state == cnmt_pkg::CNMT_PREOP |-> allow == 5'h1e)
    else $error("preop gating wrong");
  stop_gate_a: assert property (state == cnmt_pkg::CNMT_STOPPED |-> allow == 5'h02)
    else $error("stopped gating wrong");
  start_go_a: assert property (start_me && state == cnmt_pkg::CNMT_PREOP && comm_err == 3'h0 |-> ##2 state == cnmt_pkg::CNMT_OPER)
    else $error("start not obeyed");
  tpdo_burst_a: assert property ($rose(state == cnmt_pkg::CNMT_OPER) |-> tpdo_send == tpdo_enable)
    else $error("tpdo burst wrong");
  boot_msg_a: assert property (!$past(run) && state == cnmt_pkg::CNMT_PREOP |-> bootup_send)
    else $error("boot-up missing");
  boot_once_a: assert property (bootup_send |=> !bootup_send)
    else $error("boot-up too long");
  err_react_a: assert property (run && comm_err != 3'h0 && !$past(frame_valid) |=> state == (comm_err_reaction == 8'h02 ? cnmt_pkg::CNMT_STOPPED : comm_err_reaction == 8'h00 ? cnmt_pkg::CNMT_PREOP : $past(state)))
    else $error("error reaction wrong");
  guard_code_a: assert property (run |-> guard_state_byte[6:0] == code)
    else $error("guard code wrong");
  guard_tog_a: assert property (run && guard_reply_sent |=> !run || guard_state_byte[7] != $past(guard_state_byte[7]))
    else $error("guard toggle wrong");
  node_reset_a: assert property (reload_app_params |-> reload_comm_params && state == cnmt_pkg::CNMT_INIT_NODE)
    else $error("node reset wrong");
endmodule : cnmt_slave_props

bind cnmt_slave cnmt_slave_props #(.TPDO_COUNT(TPDO_COUNT)) u_cnmt_slave_props (.clk(clk), .reset(reset),
  .node_id(node_id), .frame_valid(frame_valid), .frame(frame), .comm_err_reaction(comm_err_reaction),
  .tpdo_enable(tpdo_enable), .comm_err(comm_err), .guard_reply_sent(guard_reply_sent), .state(state),
  .allow(allow), .bootup_send(bootup_send), .tpdo_send(tpdo_send), .reload_app_params(reload_app_params),
  .reload_comm_params(reload_comm_params), .guard_state_byte(guard_state_byte));

/* verification/cnmt_slave_tb_top.sv */
// Self-checking bench of the network-management slave.
`define chk(n, e, a) begin samples_checked++; if ((a) !== (e)) begin failures++; \
  $display("unexpected %s expected %h seen %h", n, e, a); end end
module cnmt_slave_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic frame_valid;
  cnmt_pkg::cnmt_frame_t frame;
  logic [7:0] react = 8'h00;
  cnmt_pkg::cnmt_err_t err = '0;
  logic guard_sent = 1'b0;
  cnmt_pkg::cnmt_state_t state;
  cnmt_pkg::cnmt_allow_t allow;
  logic boot;
  logic [3:0] tpdo;
  logic app_re;
  logic comm_re;
  logic [7:0] gbyte;
  logic [7:0] hbyte;
  logic app_seen;
  logic comm_seen;
  logic g7;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  cnmt_slave #(.TPDO_COUNT(4), .INIT_CYCLES(2)) u_cnmt_slave (.clk(clk), .reset(reset), .node_id(7'h05),
    .frame_valid(frame_valid), .frame(frame), .comm_err_reaction(react), .tpdo_enable(4'h9), .comm_err(err),
    .guard_reply_sent(guard_sent), .state(state), .allow(allow), .bootup_send(boot), .tpdo_send(tpdo),
    .reload_app_params(app_re), .reload_comm_params(comm_re), .guard_state_byte(gbyte),
    .heartbeat_state_byte(hbyte));
  cnmt_master u_cnmt_master (.clk(clk), .frame_valid(frame_valid), .frame(frame));
  // The clock toggles every 12.5 ns, giving a period of 25 ns.
  always #12.5 clk = ~clk;
  // Cycle ceiling, so a hung wait still reaches the verdict.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      results();
    end
  end
  task automatic results;
    if (failures == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results
  // Bounded wait for a state, collecting reload pulses on the way.
  task automatic wait_st(input cnmt_pkg::cnmt_state_t exp);
    int n;
    n = 0;
    app_seen = 1'b0;
    comm_seen = 1'b0;
    while (state !== exp && n < 10) begin
      @(posedge clk);
      #1;
      n++;
      app_seen |= app_re;
      comm_seen |= comm_re;
    end
    `chk("state", exp, state)
  endtask : wait_st
  task automatic cmd(input logic [7:0] code, input logic [6:0] node, input cnmt_pkg::cnmt_state_t exp);
    u_cnmt_master.send(11'h000, code, node);
    wait_st(exp);
  endtask : cmd
  task automatic t_start;
    cmd(cnmt_pkg::CMD_START, 7'h05, cnmt_pkg::CNMT_OPER);
    `chk("tpdo", 4'h9, tpdo)
    `chk("allow", 5'h1f, allow)
    repeat (2) @(posedge clk);
    `chk("heartbeat", 8'h05, hbyte)
  endtask : t_start
  // Wrong identifier, unknown code and a foreign node all leave the state alone.
  task automatic t_refuse;
    u_cnmt_master.send(11'h001, cnmt_pkg::CMD_STOP, 7'h05);
    u_cnmt_master.send(11'h000, 8'h55, 7'h05);
    u_cnmt_master.send(11'h000, cnmt_pkg::CMD_STOP, 7'h06);
    repeat (6) @(posedge clk);
    `chk("state", cnmt_pkg::CNMT_OPER, state)
  endtask : t_refuse
  task automatic t_guard;
    @(posedge clk);
    #1;
    g7 = gbyte[7];
    guard_sent = 1'b1;
    @(posedge clk);
    #1;
    guard_sent = 1'b0;
    repeat (2) @(posedge clk);
    `chk("toggle", ~g7, gbyte[7])
  endtask : t_guard
  // Reactions 00, 01 and 02, each latched by a communication reset, each fed a different error.
  task automatic t_err;
    cnmt_pkg::cnmt_state_t exp [3];
    exp = '{cnmt_pkg::CNMT_PREOP, cnmt_pkg::CNMT_OPER, cnmt_pkg::CNMT_STOPPED};
    for (int i = 0; i < 3; i++) begin
      cmd(cnmt_pkg::CMD_START, 7'h05, cnmt_pkg::CNMT_OPER);
      react = 8'(i);
      cmd(cnmt_pkg::CMD_RESET_COMM, 7'h05, cnmt_pkg::CNMT_PREOP);
      `chk("comm reload", 1'b1, comm_seen)
      `chk("app reload", 1'b0, app_seen)
      cmd(cnmt_pkg::CMD_START, 7'h05, cnmt_pkg::CNMT_OPER);
      err = cnmt_pkg::cnmt_err_t'(3'h1 << i);
      @(posedge clk);
      #1;
      err = '0;
      repeat (3) @(posedge clk);
      `chk("reaction", exp[i], state)
    end
  endtask : t_err
  initial begin
    repeat (12) @(posedge clk);
    #1;
    reset = 1'b0;
    wait_st(cnmt_pkg::CNMT_PREOP);
    `chk("boot", 1'b1, boot)
    `chk("allow", 5'h1e, allow)
    t_start();
    t_refuse();
    t_guard();
    cmd(cnmt_pkg::CMD_STOP, 7'h00, cnmt_pkg::CNMT_STOPPED);
    `chk("allow", 5'h02, allow)
    cmd(cnmt_pkg::CMD_PREOP, 7'h05, cnmt_pkg::CNMT_PREOP);
    t_start();
    cmd(cnmt_pkg::CMD_RESET_NODE, 7'h05, cnmt_pkg::CNMT_PREOP);
    `chk("app reload", 1'b1, app_seen)
    t_err();
    results();
  end
endmodule : cnmt_slave_tb_top
